// >>> core/vrw_core.sv
// Refresh timing, precharge and host ready control with an AXI4-Lite config port
`timescale 1ns/100ps
`include "vrw_regs.svh"

module vrw_core (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output      logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output      logic        S_AXI_WREADY_OUT,
  output      logic [1:0]  S_AXI_BRESP_OUT,
  output      logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output      logic        S_AXI_ARREADY_OUT,
  output      logic [31:0] S_AXI_RDATA_OUT,
  output      logic [1:0]  S_AXI_RRESP_OUT,
  output      logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        CHIP_SELECT_B_IN,
  input  wire logic        ACCESS_REQUEST_B_IN,
  input  wire logic [1:0]  BANK_SELECT_IN,
  input  wire logic        BYTE_COLUMN_ENABLE_B_IN,
  input  wire logic        EXTRA_WAIT_REQUEST_B_IN,
  input  wire logic        SECOND_PORT_GRANT_IN,
  input  wire logic        REFRESH_REQUEST_B_IN,
  input  wire logic        AUTO_REFRESH_DISABLE_B_IN,
  input  wire logic        REFRESH_EXTEND_B_IN,
  input  wire logic        SHIFT_LOAD_ADVANCE_REQUEST_B_IN,
  input  wire logic        SHIFT_LOAD_STROBE_B_IN,
  output      logic [3:0]  RAS_B_OUT,
  output      logic        DATA_ACKNOWLEDGE_B_OUT,
  output      logic        TRANSFER_OUTPUT_ENABLE_B_OUT,
  output      logic        REFRESH_IN_PROGRESS_OUT
);

  // ================================================================
  // Decoded inputs and config fields
  vrw_pkg::vrw_state_t q;
  vrw_pkg::vrw_state_t s;
  logic            access_request;
  logic            chip_select;
  logic            byte_column_enable;
  logic            extra_wait_request;
  logic            refresh_request;
  logic            auto_refresh_disable;
  logic            refresh_extend;
  logic            shift_load_strobe;
  logic            shift_load_advance_request;
  logic            ready_style_select;
  logic [1:0]      ready_delay_select;
  logic            half_level;
  logic [3:0]      pre_edges;
  logic [3:0]      low_edges;
  logic [3:0]      extra_edges;
  logic [3:0]      ready_target;
  logic [3:0]      rf_last_cnt;
  logic            rf_last;
  logic            rf_end;
  logic            rf_start;
  logic            acc_end;
  logic            timer_clear;
  logic            timer_tick;
  logic            aw_take;
  logic            ar_take;
  logic [3:0]      pre_ok;
  logic [3:0][3:0] pre_nxt;

  assign access_request             = ~ACCESS_REQUEST_B_IN;
  assign chip_select                = ~CHIP_SELECT_B_IN;
  assign byte_column_enable         = ~BYTE_COLUMN_ENABLE_B_IN;
  assign extra_wait_request         = ~EXTRA_WAIT_REQUEST_B_IN;
  assign refresh_request            = ~REFRESH_REQUEST_B_IN;
  assign auto_refresh_disable       = ~AUTO_REFRESH_DISABLE_B_IN;
  assign refresh_extend             = ~REFRESH_EXTEND_B_IN;
  assign shift_load_strobe          = ~SHIFT_LOAD_STROBE_B_IN;
  assign shift_load_advance_request = ~SHIFT_LOAD_ADVANCE_REQUEST_B_IN;
  assign ready_style_select         = q.cfg[`VRW_CFG_STYLE];
  assign ready_delay_select         = {q.cfg[`VRW_CFG_DELAY_HI], q.cfg[`VRW_CFG_DELAY_LO]};
  assign half_level                 = ~ready_delay_select[0];
  assign pre_edges   = `VRW_PRE_BASE + {3'h0, q.cfg[`VRW_CFG_PRE_HI]};
  assign low_edges   = `VRW_LOW_BASE + {3'h0, q.cfg[`VRW_CFG_PRE_LO]};
  // Half-clock levels round up to the next rising edge, after the extra edges
  assign extra_edges = !extra_wait_request ? 4'h0 :
                       (q.cfg[`VRW_CFG_EXTRA_CNT] ? 4'h2 : 4'h1);
  assign ready_target = {3'h0, ready_delay_select[1]} + {3'h0, ready_delay_select[0]}
                      + extra_edges + {3'h0, half_level};

  // ================================================================
  // Refresh arbitration
  assign rf_last_cnt = q.cfg[`VRW_CFG_STAGGER] ? low_edges + 4'h2 : low_edges - 4'h1;
  // Staggered refresh never looks at the extend input
  assign rf_last = q.cfg[`VRW_CFG_STAGGER] ? (q.rf_cnt == rf_last_cnt) :
                   ((q.rf_cnt >= rf_last_cnt) && !refresh_extend);
  assign rf_end  = (q.rf_state == vrw_pkg::RF_ACTIVE) && rf_last;
  // The advance load request blocks refresh as if an access were running
  assign rf_start = (q.rf_state == vrw_pkg::RF_IDLE) && (&pre_ok)
                 && (q.acc_state != vrw_pkg::ACC_COUNT) && (q.acc_state != vrw_pkg::ACC_DONE)
                 && !shift_load_advance_request && !q.sl_active
                 && (q.rf_latch || (q.rf_auto && !auto_refresh_disable));
  assign acc_end = ((q.acc_state == vrw_pkg::ACC_COUNT) || (q.acc_state == vrw_pkg::ACC_DONE))
                && !access_request;
  assign timer_clear = refresh_request && !auto_refresh_disable
                    && (q.clr_cnt >= `VRW_CLEAR_CYC - 7'h1);
  assign timer_tick  = !auto_refresh_disable && !timer_clear
                    && (q.rf_timer == `VRW_REFRESH_REQUEST_IN_PERIOD_CYC - 11'h1);
  assign aw_take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !q.bvalid;
  assign ar_take = S_AXI_ARVALID_IN && !q.rvalid;

  // ================================================================
  // Per-RAS precharge counters
  for (genvar i = 0; i < 4; i++) begin : g_pre
    logic load;
    // The edge that sees the request negated is the first precharge edge
    assign load       = rf_end || (acc_end && (q.acc_bank == 2'(i)));
    assign pre_ok[i]  = (q.pre_cnt[i] == 4'h0);
    assign pre_nxt[i] = load ? pre_edges - 4'h1 : (pre_ok[i] ? 4'h0 : q.pre_cnt[i] - 4'h1);
  end

  // ================================================================
  // Next state
  always_comb begin
    s = q;
    // Register bus, both write channels taken together
    if (aw_take) begin
      s.bvalid = 1'b1;
      s.bresp  = `VRW_AXI_OKAY;
      if (S_AXI_AWADDR_IN == `VRW_CONFIG_OFF) begin
        if (S_AXI_WSTRB_IN[0]) begin
          s.cfg = S_AXI_WDATA_IN[7:0];
        end
      end else if (S_AXI_AWADDR_IN != `VRW_STATUS_OFF) begin
        s.bresp = `VRW_AXI_SLVERR;
      end
    end else if (q.bvalid && S_AXI_BREADY_IN) begin
      s.bvalid = 1'b0;
    end
    if (ar_take) begin
      s.rvalid = 1'b1;
      s.rresp  = `VRW_AXI_OKAY;
      s.rdata  = 32'h0000_0000;
      case (S_AXI_ARADDR_IN)
        `VRW_CONFIG_OFF: begin
          s.rdata[7:0] = q.cfg;
        end
        `VRW_STATUS_OFF: begin
          s.rdata[`VRW_ST_REFRESH_IN_PROGRESS]    = q.refresh_in_progress;
          s.rdata[`VRW_ST_LATCH]   = q.rf_latch;
          s.rdata[`VRW_ST_WAITING] = (q.acc_state == vrw_pkg::ACC_PEND)
                                  || (q.acc_state == vrw_pkg::ACC_COUNT);
          s.rdata[`VRW_ST_SHIFT]   = q.sl_active;
          s.rdata[`VRW_ST_ADDR_LSB +: 22] = q.rf_addr;
        end
        default: begin
          s.rresp = `VRW_AXI_SLVERR;
        end
      endcase
    end else if (q.rvalid && S_AXI_RREADY_IN) begin
      s.rvalid = 1'b0;
    end

    // Refresh timer and its clear
    if (refresh_request && !auto_refresh_disable) begin
      s.clr_cnt = (q.clr_cnt == `VRW_CLEAR_CYC) ? q.clr_cnt : q.clr_cnt + 7'h1;
    end else begin
      s.clr_cnt = 7'h00;
    end
    if (timer_clear) begin
      s.rf_timer = 11'h000;
    end else if (!auto_refresh_disable) begin
      s.rf_timer = timer_tick ? 11'h000 : q.rf_timer + 11'h001;
    end
    s.rf_auto  = !timer_clear && (timer_tick || (q.rf_auto && !rf_end));
    // A new request in the ending cycle survives the clear
    s.rf_latch = (refresh_request && auto_refresh_disable)
              || (q.rf_latch && !rf_end);
    if (refresh_request && !auto_refresh_disable) begin
      s.rf_addr = 22'h000000;
    end else if (rf_end) begin
      s.rf_addr = q.rf_addr + 22'h000001;
    end

    // Refresh cycle
    case (q.rf_state)
      vrw_pkg::RF_IDLE: begin
        if (rf_start) begin
          s.rf_state = vrw_pkg::RF_ACTIVE;
          s.rf_cnt   = 4'h0;
          s.refresh_in_progress     = 1'b1;
        end
      end
      vrw_pkg::RF_ACTIVE: begin
        if (rf_last) begin
          s.rf_state = vrw_pkg::RF_IDLE;
          s.refresh_in_progress     = 1'b0;
        end else if (q.rf_cnt != 4'hF) begin
          s.rf_cnt = q.rf_cnt + 4'h1;
        end
      end
      default: begin
        s.rf_state = vrw_pkg::RF_IDLE;
      end
    endcase
    s.pre_cnt = pre_nxt;

    // Host access
    case (q.acc_state)
      vrw_pkg::ACC_IDLE: begin
        if (chip_select && access_request) begin
          s.acc_state = vrw_pkg::ACC_PEND;
          s.acc_bank  = BANK_SELECT_IN;
          s.acc_burst = 1'b0;
        end
      end
      vrw_pkg::ACC_PEND: begin
        if (!access_request) begin
          s.acc_state = vrw_pkg::ACC_IDLE;
        end else if (pre_ok[q.acc_bank] && (q.rf_state == vrw_pkg::RF_IDLE) && !rf_start
                     && SECOND_PORT_GRANT_IN) begin
          s.acc_state = vrw_pkg::ACC_COUNT;
          s.acc_cnt   = 4'h0;
        end
      end
      vrw_pkg::ACC_COUNT: begin
        if (!access_request) begin
          s.acc_state = vrw_pkg::ACC_IDLE;
        end else if (q.acc_burst && !byte_column_enable) begin
          s.acc_cnt = 4'h0;
        end else if (q.acc_cnt + 4'h1 >= ready_target) begin
          s.acc_state = vrw_pkg::ACC_DONE;
        end else begin
          s.acc_cnt = q.acc_cnt + 4'h1;
        end
      end
      vrw_pkg::ACC_DONE: begin
        if (!access_request) begin
          s.acc_state = vrw_pkg::ACC_IDLE;
        end else if (q.cfg[`VRW_CFG_BURST] && !byte_column_enable) begin
          s.acc_state = vrw_pkg::ACC_COUNT;
          s.acc_cnt   = 4'h0;
          s.acc_burst = 1'b1;
        end
      end
      default: begin
        s.acc_state = vrw_pkg::ACC_IDLE;
      end
    endcase

    // Shift register load
    s.sl_seen = shift_load_strobe;
    if (q.sl_active) begin
      if (!shift_load_strobe || (q.sl_cnt == `VRW_SHIFT_CLOCKS - 3'h1)) begin
        s.sl_active = 1'b0;
        s.sl_tail   = half_level;
      end else begin
        s.sl_cnt = q.sl_cnt + 3'h1;
      end
    end else begin
      s.sl_tail = 1'b0;
      if (shift_load_strobe && !q.sl_seen) begin
        s.sl_active = 1'b1;
        s.sl_cnt    = 3'h0;
      end
    end
    s.dtoe_b = !s.sl_active;

    // Ready pin: low while waiting in wait style, low when done in ack style
    if ((s.acc_state == vrw_pkg::ACC_IDLE) && !s.sl_active && !s.sl_tail) begin
      s.ready_b = 1'b1;
    end else if (ready_style_select) begin
      s.ready_b = (s.acc_state == vrw_pkg::ACC_PEND) || (s.acc_state == vrw_pkg::ACC_COUNT)
               || s.sl_active || s.sl_tail;
    end else begin
      s.ready_b = !((s.acc_state == vrw_pkg::ACC_PEND) || (s.acc_state == vrw_pkg::ACC_COUNT)
               || s.sl_active || s.sl_tail);
    end

    // RAS drive
    for (int i = 0; i < 4; i++) begin
      s.ras_b[i] = 1'b1;
      if (((s.acc_state == vrw_pkg::ACC_COUNT) || (s.acc_state == vrw_pkg::ACC_DONE))
          && (s.acc_bank == 2'(i))) begin
        s.ras_b[i] = 1'b0;
      end
      if (s.rf_state == vrw_pkg::RF_ACTIVE) begin
        if (!q.cfg[`VRW_CFG_STAGGER]) begin
          s.ras_b[i] = 1'b0;
        end else if ((s.rf_cnt >= 4'(i)) && (s.rf_cnt < 4'(i) + low_edges)) begin
          s.ras_b[i] = 1'b0;
        end
      end
    end
  end

  // ================================================================
  // State register
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      q           <= '0;
      q.acc_state <= vrw_pkg::ACC_IDLE;
      q.rf_state  <= vrw_pkg::RF_IDLE;
      q.ras_b     <= 4'hF;
      q.ready_b   <= 1'b1;
      q.dtoe_b    <= 1'b1;
      q.cfg       <= `VRW_CONFIG_RESET;
    end else begin
      q <= s;
    end
  end

  assign S_AXI_AWREADY_OUT            = aw_take;
  assign S_AXI_WREADY_OUT             = aw_take;
  assign S_AXI_BVALID_OUT             = q.bvalid;
  assign S_AXI_BRESP_OUT              = q.bresp;
  assign S_AXI_ARREADY_OUT            = !q.rvalid;
  assign S_AXI_RVALID_OUT             = q.rvalid;
  assign S_AXI_RRESP_OUT              = q.rresp;
  assign S_AXI_RDATA_OUT              = q.rdata;
  assign RAS_B_OUT                    = q.ras_b;
  assign DATA_ACKNOWLEDGE_B_OUT       = q.ready_b;
  assign TRANSFER_OUTPUT_ENABLE_B_OUT = q.dtoe_b;
  assign REFRESH_IN_PROGRESS_OUT      = q.refresh_in_progress;

  // ================================================================
  // Assertions
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence seq_rf_stag_last;
    (q.rf_state == vrw_pkg::RF_ACTIVE) && q.cfg[`VRW_CFG_STAGGER] && (q.rf_cnt == rf_last_cnt);
  endsequence
  sequence seq_ras0_release;
    $rose(RAS_B_OUT[0]) && !(q.rf_state == vrw_pkg::RF_ACTIVE);
  endsequence

  AST_STAGGER_NO_EXTEND: assert property (seq_rf_stag_last |=> !REFRESH_IN_PROGRESS_OUT)
    else $error("Staggered refresh was extended");
  AST_EXTEND_HOLDS: assert property (((q.rf_state == vrw_pkg::RF_ACTIVE) &&
      !q.cfg[`VRW_CFG_STAGGER] && refresh_extend) |=> (RAS_B_OUT == 4'h0))
    else $error("Extend did not hold refresh RAS");
  AST_ADDR_CLEAR: assert property ((refresh_request && !auto_refresh_disable)
      |=> (q.rf_addr == 22'h000000))
    else $error("Refresh address not cleared");
  AST_TIMER_QUIET: assert property (timer_clear |=> (q.rf_timer == 11'h000) && !q.rf_auto)
    else $error("Refresh timer not cleared");
  AST_PRECHARGE_WAIT: assert property (((q.acc_state == vrw_pkg::ACC_PEND)
      && !pre_ok[q.acc_bank]) |=> (q.acc_state != vrw_pkg::ACC_COUNT))
    else $error("Access RAS started before precharge");
  AST_IDLE_READY: assert property (((q.acc_state == vrw_pkg::ACC_IDLE) && !q.sl_active
      && !q.sl_tail) |-> DATA_ACKNOWLEDGE_B_OUT)
    else $error("Ready asserted outside an access");
  AST_SHIFT_HOLD: assert property (q.sl_active |-> !TRANSFER_OUTPUT_ENABLE_B_OUT
      && (DATA_ACKNOWLEDGE_B_OUT == ready_style_select))
    else $error("Shift load not holding the host");
  AST_SHIFT_END: assert property ($rose(q.sl_active) |-> ##[1:4] !q.sl_active)
    else $error("Shift load lasted beyond four clocks");
  AST_RAS_PRECHARGE: assert property (seq_ras0_release |-> RAS_B_OUT[0] [*2])
    else $error("RAS0 precharge shorter than two edges");
  AST_LATCH_CLEAR: assert property ((rf_end && !(refresh_request && auto_refresh_disable))
      |=> !q.rf_latch)
    else $error("Refresh latch not cleared at refresh end");

endmodule : vrw_core

// >>> common/vrw_regs.svh
// Register offsets, field positions, reset values and timing counts of the refresh/wait block
`ifndef VRW_REGS_SVH
`define VRW_REGS_SVH

// ==================================================================
// Register map
`define VRW_CONFIG_OFF        8'h00
`define VRW_STATUS_OFF        8'h04
`define VRW_CONFIG_RESET      8'h00

// ==================================================================
// Config fields
`define VRW_CFG_STYLE         0
`define VRW_CFG_DELAY_LO      1
`define VRW_CFG_DELAY_HI      2
`define VRW_CFG_EXTRA_CNT     3
`define VRW_CFG_PRE_LO        4
`define VRW_CFG_PRE_HI        5
`define VRW_CFG_BURST         6
`define VRW_CFG_STAGGER       7

// ==================================================================
// Status fields
`define VRW_ST_REFRESH_IN_PROGRESS           0
`define VRW_ST_LATCH          1
`define VRW_ST_WAITING        2
`define VRW_ST_SHIFT          3
`define VRW_ST_ADDR_LSB       8

// ==================================================================
// Timing
`define VRW_CLK_PERIOD_PS     32'h0000_1F40
`define VRW_REFRESH_REQUEST_IN_PERIOD_PS    32'h00E4_E1C0
`define VRW_CLEAR_TIME_PS     32'h0007_A120
`define VRW_REFRESH_REQUEST_IN_PERIOD_CYC   11'(`VRW_REFRESH_REQUEST_IN_PERIOD_PS / `VRW_CLK_PERIOD_PS)
`define VRW_CLEAR_CYC         7'((`VRW_CLEAR_TIME_PS + `VRW_CLK_PERIOD_PS - 32'h1) / `VRW_CLK_PERIOD_PS)
`define VRW_SHIFT_CLOCKS      3'h4
`define VRW_PRE_BASE          4'h2
`define VRW_LOW_BASE          4'h2
`define VRW_AXI_OKAY          2'h0
`define VRW_AXI_SLVERR        2'h2

`endif

// >>> common/vrw_pkg.sv
// Types shared by the refresh/wait block
package vrw_pkg;

  // ================================================================
  // State machines
  typedef enum logic [3:0] {
    ACC_IDLE  = 4'h1,
    ACC_PEND  = 4'h2,
    ACC_COUNT = 4'h4,
    ACC_DONE  = 4'h8
  } vrw_acc_state_t;

  typedef enum logic [1:0] {
    RF_IDLE   = 2'h1,
    RF_ACTIVE = 2'h2
  } vrw_rf_state_t;

  // ================================================================
  // Whole block state
  typedef struct packed {
    vrw_acc_state_t  acc_state;
    logic [1:0]      acc_bank;
    logic [3:0]      acc_cnt;
    logic            acc_burst;
    vrw_rf_state_t   rf_state;
    logic [3:0]      rf_cnt;
    logic [3:0][3:0] pre_cnt;
    logic            rf_latch;
    logic            rf_auto;
    logic [10:0]     rf_timer;
    logic [6:0]      clr_cnt;
    logic [21:0]     rf_addr;
    logic            sl_active;
    logic            sl_seen;
    logic            sl_tail;
    logic [2:0]      sl_cnt;
    logic [3:0]      ras_b;
    logic            ready_b;
    logic            dtoe_b;
    logic            refresh_in_progress;
    logic [7:0]      cfg;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } vrw_state_t;

endpackage : vrw_pkg

// >>> sim/vrw_host_model.sv
// Host bus master model: holds each access until the ready pin releases it
`timescale 1ns/100ps
module vrw_host_model (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  input  wire logic ack_style_in,
  input  wire logic ready_pin_in,
  output      logic cs_b_out,
  output      logic access_request_b_out,
  output      logic done_out
);
  logic waited_q;
  // ==================================================================
  // Access sequencing
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (!rst_b_in) begin
      cs_b_out <= 1'b1;
      access_request_b_out <= 1'b1;
      waited_q <= 1'b0;
    end else if (start_in) begin
      cs_b_out <= 1'b0;
      access_request_b_out <= 1'b0;
      waited_q <= 1'b0;
    end else if (!access_request_b_out) begin
      waited_q <= waited_q | !ready_pin_in;
      // Ends the cycle only once the pin is sampled released, as a real CPU would
      if (ack_style_in ? !ready_pin_in : ready_pin_in && waited_q) begin
        cs_b_out <= 1'b1;
        access_request_b_out <= 1'b1;
        done_out <= 1'b1;
      end
    end
  end
endmodule : vrw_host_model

// >>> sim/vram_refresh_wait_control_test.sv
// Self-checking bench: config bus, ready timing, refresh and shift load
`timescale 1ns/100ps
`include "vrw_regs.svh"
module vram_refresh_wait_control_test;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, rd_d;
  logic [7:0]  S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, cfg;
  logic [3:0]  S_AXI_WSTRB_IN, RAS_B_OUT;
  logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, BANK_SELECT_IN, rd_r;
  logic        CLOCK_IN, RST_B_IN, S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN;
  logic        S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_BREADY_IN, S_AXI_ARVALID_IN;
  logic        S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN, CHIP_SELECT_B_IN;
  logic        ACCESS_REQUEST_B_IN, BYTE_COLUMN_ENABLE_B_IN, EXTRA_WAIT_REQUEST_B_IN;
  logic        SECOND_PORT_GRANT_IN, REFRESH_REQUEST_B_IN, AUTO_REFRESH_DISABLE_B_IN;
  logic        REFRESH_EXTEND_B_IN, SHIFT_LOAD_ADVANCE_REQUEST_B_IN, SHIFT_LOAD_STROBE_B_IN;
  logic        DATA_ACKNOWLEDGE_B_OUT, TRANSFER_OUTPUT_ENABLE_B_OUT, REFRESH_IN_PROGRESS_OUT;
  logic        go, done, style;
  int          n_fail, n_tests, guard, seed, cnt, n3;
  // ==================================================================
  // Instances
  vrw_core dut_u (.CLOCK_IN, .RST_B_IN, .S_AXI_AWADDR_IN, .S_AXI_AWVALID_IN,
    .S_AXI_AWREADY_OUT, .S_AXI_WDATA_IN, .S_AXI_WSTRB_IN, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
    .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN,
    .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN,
    .CHIP_SELECT_B_IN, .ACCESS_REQUEST_B_IN, .BANK_SELECT_IN, .BYTE_COLUMN_ENABLE_B_IN,
    .EXTRA_WAIT_REQUEST_B_IN, .SECOND_PORT_GRANT_IN, .REFRESH_REQUEST_B_IN,
    .AUTO_REFRESH_DISABLE_B_IN, .REFRESH_EXTEND_B_IN, .SHIFT_LOAD_ADVANCE_REQUEST_B_IN,
    .SHIFT_LOAD_STROBE_B_IN, .RAS_B_OUT, .DATA_ACKNOWLEDGE_B_OUT,
    .TRANSFER_OUTPUT_ENABLE_B_OUT, .REFRESH_IN_PROGRESS_OUT);
  vrw_host_model host_u (.clk_in(CLOCK_IN), .rst_b_in(RST_B_IN), .start_in(go),
    .ack_style_in(style), .ready_pin_in(DATA_ACKNOWLEDGE_B_OUT),
    .cs_b_out(CHIP_SELECT_B_IN), .access_request_b_out(ACCESS_REQUEST_B_IN), .done_out(done));
  initial begin
    CLOCK_IN = 1'b0;
    forever #4 CLOCK_IN = ~CLOCK_IN;
  end
  // ==================================================================
  // Tasks; sampling happens at the edge, before that edge's updates land
  task wrap_up();
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task step();
    @(posedge CLOCK_IN);
    guard++;
    if (guard > 3000) begin
      n_fail++;
      wrap_up();
    end
  endtask : step
  task wr(input logic [7:0] a, input logic [31:0] d);
    guard = 0;
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= d;
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} <= 3'h7;
    do step(); while (S_AXI_AWREADY_OUT !== 1'b1);
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN} <= 2'h0;
    do step(); while (S_AXI_BVALID_OUT !== 1'b1);
    S_AXI_BREADY_IN <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    guard = 0;
    S_AXI_ARADDR_IN <= a;
    {S_AXI_ARVALID_IN, S_AXI_RREADY_IN} <= 2'h3;
    do step(); while (S_AXI_ARREADY_OUT !== 1'b1);
    S_AXI_ARVALID_IN <= 1'b0;
    do step(); while (S_AXI_RVALID_OUT !== 1'b1);
    rd_d = S_AXI_RDATA_OUT;
    rd_r = S_AXI_RRESP_OUT;
    S_AXI_RREADY_IN <= 1'b0;
  endtask : rd
  function automatic int exp_n(logic [7:0] c, logic xw);
    return 32'(c[2]) + 1 + (xw ? 32'(c[3]) + 1 : 0);
  endfunction : exp_n
  task acc(input logic [7:0] c, input logic xw);
    wr(`VRW_CONFIG_OFF, {24'h0, c});
    rd(`VRW_CONFIG_OFF);
    `CHK(rd_d, {24'h0, c})
    guard = 0;
    cnt = 0;
    style = c[0];
    EXTRA_WAIT_REQUEST_B_IN <= !xw;
    BANK_SELECT_IN <= 2'($random(seed));
    SECOND_PORT_GRANT_IN <= 1'($random(seed));
    go <= 1'b1;
    step();
    go <= 1'b0;
    do begin
      step();
      SECOND_PORT_GRANT_IN <= 1'b1;
      if (RAS_B_OUT[BANK_SELECT_IN] === 1'b0 && DATA_ACKNOWLEDGE_B_OUT === c[0]) cnt++;
    end while (done !== 1'b1);
    `CHK(cnt, exp_n(c, xw))
    repeat (2) step();
    `CHK({DATA_ACKNOWLEDGE_B_OUT, RAS_B_OUT}, 5'h1F)
  endtask : acc
  task clr();
    {AUTO_REFRESH_DISABLE_B_IN, REFRESH_REQUEST_B_IN} <= 2'h2;
    step();
    {AUTO_REFRESH_DISABLE_B_IN, REFRESH_REQUEST_B_IN} <= 2'h1;
    step();
  endtask : clr
  task refresh_request_in(input logic [7:0] c, input int x);
    int e;
    wr(`VRW_CONFIG_OFF, {24'h0, c});
    // Extend held past the ending edge lengthens all-RAS refresh only
    e = (x > 32'(c[4]) + 3) ? x - 1 : 32'(c[4]) + 2;
    cnt = 0;
    n3 = 0;
    REFRESH_REQUEST_B_IN <= 1'b0;
    step();
    REFRESH_REQUEST_B_IN <= 1'b1;
    for (int k = 2; k <= 13; k++) begin
      step();
      if (k == 2 && x > 0) REFRESH_EXTEND_B_IN <= 1'b0;
      if (k == x) REFRESH_EXTEND_B_IN <= 1'b1;
      if (RAS_B_OUT === 4'h0) cnt++;
      if (RAS_B_OUT[3] === 1'b0) n3++;
    end
    `CHK(cnt, c[7] ? 0 : e)
    `CHK(n3, c[7] ? 32'(c[4]) + 2 : e)
  endtask : refresh_request_in
  // ==================================================================
  // Main sequence
  initial begin
    {seed, n_fail, n_tests, guard} = {32'd68221, 96'h0};
    {go, style, RST_B_IN, BANK_SELECT_IN, cfg, S_AXI_WDATA_IN} = '0;
    {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, S_AXI_WSTRB_IN} = {16'h0, 4'hF};
    {S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} = 3'h0;
    {S_AXI_ARVALID_IN, S_AXI_RREADY_IN, BYTE_COLUMN_ENABLE_B_IN} = 3'h0;
    {EXTRA_WAIT_REQUEST_B_IN, SECOND_PORT_GRANT_IN, REFRESH_REQUEST_B_IN} = 3'h7;
    {AUTO_REFRESH_DISABLE_B_IN, REFRESH_EXTEND_B_IN} = 2'h1;
    {SHIFT_LOAD_ADVANCE_REQUEST_B_IN, SHIFT_LOAD_STROBE_B_IN} = 2'h3;
    repeat (12) @(posedge CLOCK_IN);
    RST_B_IN <= 1'b1;
    step();
    rd(`VRW_CONFIG_OFF);
    `CHK(rd_d, 32'h0)
    rd(8'h10);
    `CHK(rd_r, `VRW_AXI_SLVERR)
    $display("test config bus done");
    for (int i = 0; i < 16; i++) begin
      cfg = 8'($random(seed)) & 8'h3F;
      acc(cfg, 1'($random(seed)));
    end
    $display("test ready timing done");
    clr();
    refresh_request_in(8'h00, 0);
    refresh_request_in(8'h10, 0);
    refresh_request_in(8'h00, 5);
    refresh_request_in(8'h80, 5);
    rd(`VRW_STATUS_OFF);
    `CHK(rd_d[29:8], 22'h4)
    clr();
    rd(`VRW_STATUS_OFF);
    `CHK(rd_d[29:8], 22'h0)
    $display("test refresh done");
    wr(`VRW_CONFIG_OFF, 32'h0);
    {AUTO_REFRESH_DISABLE_B_IN, REFRESH_REQUEST_B_IN} <= 2'h2;
    repeat (70) step();
    REFRESH_REQUEST_B_IN <= 1'b1;
    cnt = 0;
    repeat (1800) begin
      step();
      if (REFRESH_IN_PROGRESS_OUT === 1'b1) cnt++;
    end
    `CHK(cnt, 0)
    repeat (200) begin
      step();
      if (REFRESH_IN_PROGRESS_OUT === 1'b1) cnt++;
    end
    `CHK(cnt, 2)
    AUTO_REFRESH_DISABLE_B_IN <= 1'b0;
    $display("test refresh timer done");
    for (int h = 2; h <= 10; h += 8) begin
      cnt = 0;
      SHIFT_LOAD_ADVANCE_REQUEST_B_IN <= 1'b0;
      step();
      SHIFT_LOAD_STROBE_B_IN <= 1'b0;
      for (int k = 0; k < 12; k++) begin
        step();
        if (k == h - 1) SHIFT_LOAD_STROBE_B_IN <= 1'b1;
        if (TRANSFER_OUTPUT_ENABLE_B_OUT === 1'b0) begin
          cnt++;
          `CHK(DATA_ACKNOWLEDGE_B_OUT, 1'b0)
        end
      end
      SHIFT_LOAD_ADVANCE_REQUEST_B_IN <= 1'b1;
      `CHK(cnt, (h < 4) ? h : 4)
    end
    $display("test shift load done");
    wrap_up();
  end
endmodule : vram_refresh_wait_control_test
